// ---- hdl/sdcd_dev.sv ----
// Device end: registers and decodes commands, keeps mode and refresh state.
// Assumes pins are synchronous to clk_sys; decoded outputs drive the core.
`timescale 1ns/10ps
`default_nettype none
`include "sdcd_defines.svh"
module sdcd_dev
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // Pins
  sdcd_if.dev                          pins,
  // Decoded command, one cycle each
  output logic                         cmd_valid,
  output sdcd_pkg::sdcd_cmd_e          cmd,
  output logic [`SDCD_BANK_W-1:0]      cmd_bank,
  output logic [`SDCD_ADDR_W-1:0]      cmd_addr,
  output logic [`SDCD_ADDR_W-1:0]      refresh_row,
  // Write data word, one cycle each
  output logic                         wdata_store,
  output logic [`SDCD_DATA_W-1:0]      wdata,
  // Mode state
  output logic [`SDCD_MODE_W-1:0]      mode_value
);
  // Command group
  sdcd_pkg::sdcd_cmd_e              cmd_r, cmd_nxt;
  logic                             vld_r, vld_nxt;
  logic [`SDCD_BANK_W-1:0]          bank_r, bank_nxt;
  logic [`SDCD_ADDR_W-1:0]          addr_r, addr_nxt;
  // Mode group
  logic [`SDCD_MODE_W-1:0]          mode_r, mode_nxt;
  // Refresh group, one row counter per bank
  logic [`SDCD_ADDR_W-1:0]          row_r [0:7];
  logic [`SDCD_ADDR_W-1:0]          row_nxt [0:7];
  logic [`SDCD_ADDR_W-1:0]          rowo_r, rowo_nxt;
  // Write data group
  logic                             st_r, st_nxt;
  logic [`SDCD_DATA_W-1:0]          wd_r, wd_nxt;
  // Decode of the sampled strobes
  logic                             dec_mode;
  logic                             dec_read;
  logic                             dec_write;
  logic                             dec_refr;
  logic [1:0]                       bl;
  logic [`SDCD_ADDR_W-1:0]          acc_mask;

  assign bl = mode_r[`SDCD_BL_LSB+1:`SDCD_BL_LSB];

  // Select high turns every other strobe into don't care
  always_comb
  begin
    dec_mode  = 1'b0;
    dec_read  = 1'b0;
    dec_write = 1'b0;
    dec_refr  = 1'b0;
    if (!pins.sel_n)
    begin
      case ({pins.wr_n, pins.ref_n})
        2'b00:   dec_mode  = 1'b1;
        2'b11:   dec_read  = 1'b1;
        2'b01:   dec_write = 1'b1;
        2'b10:   dec_refr  = 1'b1;
        default: dec_mode  = 1'b0;
      endcase
    end
  end

  // Top address bits cleared by burst length: none for BL2, one for BL4, two otherwise
  always_comb
  begin
    case (bl)
      `SDCD_BL2: acc_mask = {`SDCD_ADDR_W{1'b1}};
      `SDCD_BL4: acc_mask = {1'b0, {(`SDCD_ADDR_W-1){1'b1}}};
      default:   acc_mask = {2'b00, {(`SDCD_ADDR_W-2){1'b1}}};
    endcase
  end

  always_comb
  begin
    cmd_nxt  = sdcd_pkg::SDCD_CMD_IDLE;
    vld_nxt  = 1'b0;
    bank_nxt = '0;
    addr_nxt = '0;
    if (dec_mode)
    begin
      cmd_nxt = sdcd_pkg::SDCD_CMD_MODE;
      vld_nxt = 1'b1;
    end
    else if (dec_read || dec_write)
    begin
      cmd_nxt  = dec_read ? sdcd_pkg::SDCD_CMD_READ : sdcd_pkg::SDCD_CMD_WRITE;
      vld_nxt  = 1'b1;
      bank_nxt = pins.bank_select;
      addr_nxt = pins.addr & acc_mask;
    end
    else if (dec_refr)
    begin
      cmd_nxt  = sdcd_pkg::SDCD_CMD_REFR;
      vld_nxt  = 1'b1;
      bank_nxt = pins.bank_select;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      cmd_r  <= sdcd_pkg::SDCD_CMD_IDLE;
      vld_r  <= 1'b0;
      bank_r <= '0;
      addr_r <= '0;
    end
    else
    begin
      cmd_r  <= cmd_nxt;
      vld_r  <= vld_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
    end
  end

  // Only the low eighteen address bits reach the mode value
  always_comb
  begin
    mode_nxt = mode_r;
    if (dec_mode)
      mode_nxt = pins.addr[`SDCD_MODE_W-1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      mode_r <= `SDCD_MODE_RST;
    else
      mode_r <= mode_nxt;
  end

  // Row comes from the bank's own counter; address pins play no part
  always_comb
  begin
    row_nxt  = row_r;
    rowo_nxt = rowo_r;
    if (dec_refr)
    begin
      rowo_nxt = row_r[pins.bank_select];
      row_nxt[pins.bank_select] = row_r[pins.bank_select] + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rowo_r <= '0;
      for (int i = 0; i < 8; i++)
        row_r[i] <= '0;
    end
    else
    begin
      rowo_r <= rowo_nxt;
      row_r  <= row_nxt;
    end
  end

  // Mask registered with its word; high discards the word
  always_comb
  begin
    st_nxt = !pins.write_word_mask;
    wd_nxt = pins.write_data_inputs;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_r <= 1'b0;
      wd_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      wd_r <= wd_nxt;
    end
  end

  assign cmd_valid   = vld_r;
  assign cmd         = cmd_r;
  assign cmd_bank    = bank_r;
  assign cmd_addr    = addr_r;
  assign refresh_row = rowo_r;
  assign wdata_store = st_r;
  assign wdata       = wd_r;
  assign mode_value  = mode_r;
endmodule : sdcd_dev
`default_nettype wire

// ---- hdl/sdcd_defines.svh ----
// Constants for the command decode link: field positions, widths, encodings.
// Assumes inclusion by bare name from design files.
`ifndef SDCD_DEFINES_SVH
`define SDCD_DEFINES_SVH
`define SDCD_ADDR_W      20
`define SDCD_BANK_W      3
`define SDCD_DATA_W      18
`define SDCD_MODE_W      18
`define SDCD_BL_LSB      3
`define SDCD_BL2         2'b00
`define SDCD_BL4         2'b01
`define SDCD_BL8         2'b10
`define SDCD_MODE_RST    18'h00000
`define SDCD_RECOV_NS    40
`define SDCD_CLK_NS      40
`define SDCD_RECOV_CYC   (((`SDCD_RECOV_NS) + (`SDCD_CLK_NS) - 1) / (`SDCD_CLK_NS))
`endif

// ---- hdl/sdcd_pkg.sv ----
// Types shared by both ends of the command decode link.
// Assumes sdcd_defines.svh is on the include path.
`include "sdcd_defines.svh"
package sdcd_pkg;
  typedef enum logic [4:0]
  {
    SDCD_CMD_IDLE  = 5'h01,
    SDCD_CMD_MODE  = 5'h02,
    SDCD_CMD_READ  = 5'h04,
    SDCD_CMD_WRITE = 5'h08,
    SDCD_CMD_REFR  = 5'h10
  } sdcd_cmd_e;
  typedef logic [`SDCD_ADDR_W-1:0] sdcd_addr_t;
  typedef logic [`SDCD_BANK_W-1:0] sdcd_bank_t;
endpackage : sdcd_pkg

// ---- hdl/sdcd_if.sv ----
// Command and write-data pins between controller and memory device.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "sdcd_defines.svh"
interface sdcd_if;
  logic                    sel_n;
  logic                    wr_n;
  logic                    ref_n;
  logic [`SDCD_BANK_W-1:0] bank_select;
  logic [`SDCD_ADDR_W-1:0] addr;
  logic [`SDCD_DATA_W-1:0] write_data_inputs;
  logic                    write_word_mask;
  modport ctrl (output sel_n, wr_n, ref_n, bank_select, addr, write_data_inputs, write_word_mask);
  modport dev  (input sel_n, wr_n, ref_n, bank_select, addr, write_data_inputs, write_word_mask);
endinterface : sdcd_if
`default_nettype wire

// ---- hdl/sdcd_ctrl.sv ----
// Controller end: turns user requests into legal pin commands.
// Assumes user requests are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "sdcd_defines.svh"
module sdcd_ctrl
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // User request
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire sdcd_pkg::sdcd_cmd_e     req_cmd,
  input  wire logic [`SDCD_BANK_W-1:0] req_bank,
  input  wire logic [`SDCD_ADDR_W-1:0] req_addr,
  input  wire logic                    banks_idle,
  // User write data
  input  wire logic [`SDCD_DATA_W-1:0] wr_data,
  input  wire logic                    wr_mask,
  // Pins
  sdcd_if.ctrl                         pins
);
  logic                            sel_r, sel_nxt, wr_r, wr_nxt, rf_r, rf_nxt, msk_r, msk_nxt;
  logic [`SDCD_BANK_W-1:0]         bank_r, bank_nxt;
  logic [`SDCD_ADDR_W-1:0]         addr_r, addr_nxt;
  logic [`SDCD_DATA_W-1:0]         wd_r, wd_nxt;
  logic [3:0]                      wait_r, wait_nxt;
  logic                            ok;

  // Mode set held off until banks idle; back-to-back mode sets allowed
  assign ok = (wait_r == 4'h0) || (req_cmd == sdcd_pkg::SDCD_CMD_MODE);
  assign req_ready = ok && !(req_cmd == sdcd_pkg::SDCD_CMD_MODE && !banks_idle);

  always_comb
  begin
    sel_nxt  = 1'b1;
    wr_nxt   = 1'b1;
    rf_nxt   = 1'b1;
    bank_nxt = '0;
    addr_nxt = '0;
    wait_nxt = (wait_r != 4'h0) ? wait_r - 4'h1 : 4'h0;
    msk_nxt  = wr_mask;
    wd_nxt   = wr_data;
    if (req_valid && req_ready)
    begin
      case (req_cmd)
        sdcd_pkg::SDCD_CMD_MODE:
        begin
          sel_nxt  = 1'b0;
          wr_nxt   = 1'b0;
          rf_nxt   = 1'b0;
          addr_nxt = {2'b00, req_addr[`SDCD_MODE_W-1:0]};
          wait_nxt = 4'(`SDCD_RECOV_CYC);
        end
        sdcd_pkg::SDCD_CMD_READ, sdcd_pkg::SDCD_CMD_WRITE:
        begin
          sel_nxt  = 1'b0;
          wr_nxt   = (req_cmd == sdcd_pkg::SDCD_CMD_READ);
          bank_nxt = req_bank;
          addr_nxt = req_addr;
        end
        sdcd_pkg::SDCD_CMD_REFR:
        begin
          sel_nxt  = 1'b0;
          rf_nxt   = 1'b0;
          bank_nxt = req_bank;
        end
        default:
        begin
          sel_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sel_r  <= 1'b1;
      wr_r   <= 1'b1;
      rf_r   <= 1'b1;
      bank_r <= '0;
      addr_r <= '0;
      wait_r <= 4'h0;
      msk_r  <= 1'b1;
      wd_r   <= '0;
    end
    else
    begin
      sel_r  <= sel_nxt;
      wr_r   <= wr_nxt;
      rf_r   <= rf_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
      wait_r <= wait_nxt;
      msk_r  <= msk_nxt;
      wd_r   <= wd_nxt;
    end
  end

  assign pins.sel_n             = sel_r;
  assign pins.wr_n              = wr_r;
  assign pins.ref_n             = rf_r;
  assign pins.bank_select       = bank_r;
  assign pins.addr              = addr_r;
  assign pins.write_data_inputs = wd_r;
  assign pins.write_word_mask   = msk_r;
endmodule : sdcd_ctrl
`default_nettype wire

// ---- verif/sdcd_chk.sv ----
// Checker on the pins joining controller and device ends.
// Assumes pins change only after rising clk_sys; rst_n synchronous, active low.
`timescale 1ns/10ps
`default_nettype none
`include "sdcd_defines.svh"
module sdcd_chk
(
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  // Command strobes
  input wire logic                    sel_n,
  input wire logic                    wr_n,
  input wire logic                    ref_n,
  // Bank and address
  input wire logic [`SDCD_BANK_W-1:0] bank_select,
  input wire logic [`SDCD_ADDR_W-1:0] addr
);
  a_idle_strobes_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sel_n |-> (wr_n && ref_n))
    else $error("strobes not high while deselected");
  a_mode_high_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!sel_n && !wr_n && !ref_n) |-> (addr[`SDCD_ADDR_W-1:`SDCD_MODE_W] == 2'b00))
    else $error("mode set drives address bits above the opcode");
  a_mode_bank_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!sel_n && !wr_n && !ref_n) |-> (bank_select == '0))
    else $error("mode set drives a bank");
  a_refresh_addr_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!sel_n && wr_n && !ref_n) |-> (addr == '0))
    else $error("refresh drives an address");
  a_mode_set_recovery: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!sel_n && !wr_n && !ref_n) |=> (sel_n || (!wr_n && !ref_n)))
    else $error("command issued inside mode set recovery");
  a_reset_deselect: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (sel_n && wr_n && ref_n))
    else $error("strobes not idle after reset");
endmodule : sdcd_chk
`default_nettype wire

// ---- verif/sram_style_dram_command_decode_tb.sv ----
// Testbench joining controller and device ends through the pin interface.
// Assumes sdcd_pkg and sdcd_defines.svh are compiled and on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "sdcd_defines.svh"
module sram_style_dram_command_decode_tb;
  logic                clk_sys    = 1'b0;
  logic                rst_n      = 1'b0;
  logic                req_valid  = 1'b0;
  logic                req_ready;
  sdcd_pkg::sdcd_cmd_e req_cmd    = sdcd_pkg::SDCD_CMD_IDLE;
  logic [2:0]          req_bank   = 3'h0;
  logic [19:0]         req_addr   = 20'h00000;
  logic                banks_idle = 1'b1;
  logic [17:0]         wr_data    = 18'h00000;
  logic                wr_mask    = 1'b1;
  logic                cmd_valid;
  logic                wdata_store;
  sdcd_pkg::sdcd_cmd_e cmd;
  logic [2:0]          cmd_bank;
  logic [19:0]         cmd_addr;
  logic [19:0]         refresh_row;
  logic [17:0]         wdata;
  logic [17:0]         mode_value;
  int                  err_count  = 0;
  int                  num_checks = 0;
  int                  cyc        = 0;
  sdcd_if pins ();
  sdcd_ctrl u_sdcd_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .banks_idle(banks_idle), .wr_data(wr_data), .wr_mask(wr_mask), .pins(pins));
  sdcd_dev u_sdcd_dev (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .refresh_row(refresh_row),
    .wdata_store(wdata_store), .wdata(wdata), .mode_value(mode_value));
  sdcd_chk u_sdcd_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sel_n(pins.sel_n),
    .wr_n(pins.wr_n), .ref_n(pins.ref_n), .bank_select(pins.bank_select), .addr(pins.addr));
  always #20 clk_sys = ~clk_sys;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [19:0] exp, input logic [19:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  // Request taken at a rising edge; device outputs stand after the next edge
  task automatic issue(input sdcd_pkg::sdcd_cmd_e c, input logic [2:0] b, input logic [19:0] a);
    int n;
    n = 0;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_valid = 1'b1;
    #1;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 20)
    begin
      $display("[ERR] req_ready expected 1 seen %b", req_ready);
      err_count++;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask : issue
  task automatic expect_cmd(input sdcd_pkg::sdcd_cmd_e c, input logic [2:0] b, input logic [19:0] a);
    chk("cmd_valid", 20'h1, {19'h0, cmd_valid});
    chk("cmd", {15'h0, c}, {15'h0, cmd});
    chk("cmd_bank", {17'h0, b}, {17'h0, cmd_bank});
    chk("cmd_addr", a, cmd_addr);
  endtask : expect_cmd
  task automatic t_refresh();
    issue(sdcd_pkg::SDCD_CMD_REFR, 3'h5, 20'hfffff);
    expect_cmd(sdcd_pkg::SDCD_CMD_REFR, 3'h5, 20'h00000);
    chk("refresh_row", 20'h00000, refresh_row);
    issue(sdcd_pkg::SDCD_CMD_REFR, 3'h5, 20'h12345);
    chk("refresh_row", 20'h00001, refresh_row);
    issue(sdcd_pkg::SDCD_CMD_REFR, 3'h6, 20'h00000);
    chk("refresh_row", 20'h00000, refresh_row);
    $display("t_refresh done");
  endtask : t_refresh
  task automatic t_mode_width();
    issue(sdcd_pkg::SDCD_CMD_MODE, 3'h7, 20'hc0018);
    expect_cmd(sdcd_pkg::SDCD_CMD_MODE, 3'h0, 20'h00000);
    chk("mode_value", 20'h00018, {2'h0, mode_value});
    for (int i = 0; i < 3; i++)
    begin
      issue(sdcd_pkg::SDCD_CMD_MODE, 3'h0, {15'h0, i[1:0], 3'h0});
      issue(sdcd_pkg::SDCD_CMD_READ, 3'h2, 20'hfffff);
      expect_cmd(sdcd_pkg::SDCD_CMD_READ, 3'h2, 20'hfffff >> i);
    end
    issue(sdcd_pkg::SDCD_CMD_WRITE, 3'h3, 20'hfffff);
    expect_cmd(sdcd_pkg::SDCD_CMD_WRITE, 3'h3, 20'h3ffff);
    $display("t_mode_width done");
  endtask : t_mode_width
  task automatic t_refuse();
    banks_idle = 1'b0;
    req_cmd = sdcd_pkg::SDCD_CMD_MODE;
    req_addr = 20'h00000;
    req_valid = 1'b1;
    #1;
    chk("req_ready busy banks", 20'h0, {19'h0, req_ready});
    banks_idle = 1'b1;
    @(negedge clk_sys);
    req_cmd = sdcd_pkg::SDCD_CMD_READ;
    #1;
    chk("req_ready recovery", 20'h0, {19'h0, req_ready});
    req_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_mask_idle();
    for (int m = 0; m < 2; m++)
    begin
      wr_mask = m[0];
      wr_data = 18'h2aaaa ^ m[17:0];
      repeat (2) @(negedge clk_sys);
      chk("wdata_store", {19'h0, ~m[0]}, {19'h0, wdata_store});
      chk("wdata", {2'h0, 18'h2aaaa ^ m[17:0]}, {2'h0, wdata});
      chk("cmd_valid idle", 20'h0, {19'h0, cmd_valid});
      chk("cmd idle", {15'h0, sdcd_pkg::SDCD_CMD_IDLE}, {15'h0, cmd});
    end
    $display("t_mask_idle done");
  endtask : t_mask_idle
  initial
  begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_refresh();
    t_mode_width();
    t_refuse();
    t_mask_idle();
    wrap_up();
  end
endmodule : sram_style_dram_command_decode_tb
`default_nettype wire
